// [bench/rxs_host_mem.sv]
`timescale 1ns/10ps

module rxs_host_mem (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        slow_i,
    input  wire logic        wb_valid_i,
    input  wire logic [31:0] wb_addr_i,
    input  wire logic [31:0] wb_data_i,
    output logic             wb_ready_o,
    output logic      [31:0] head_o,
    output logic      [31:0] tag_o,
    output logic      [31:0] addr_o,
    output logic      [7:0]  heads_o
);
    logic [1:0]  ph;
    logic [31:0] pend;

    // slow mode takes one beat in three, like a busy memory
    assign wb_ready_o = !slow_i || ph == 2'h2;

    // status is read only once the ownership word lands cleared
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph      <= 2'h0;
            pend    <= 32'h0;
            head_o  <= 32'h0;
            tag_o   <= 32'h0;
            addr_o  <= 32'h0;
            heads_o <= 8'h0;
        end else begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            if (wb_valid_i && wb_ready_o && wb_addr_i[3:0] == 4'h4) begin
                pend <= wb_data_i;
            end
            if (wb_valid_i && wb_ready_o && wb_addr_i[3:0] == 4'h0 && !wb_data_i[31]) begin
                head_o  <= wb_data_i;
                tag_o   <= pend;
                addr_o  <= wb_addr_i;
                heads_o <= heads_o + 8'h1;
            end
        end
    end
endmodule // rxs_host_mem

// [bench/rxs_wb_asserts.sv]
`timescale 1ns/10ps

module rxs_wb_chk (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        seg_valid_i,
    input wire logic        seg_ready_o,
    input wire logic        seg_first_i,
    input wire logic        seg_last_i,
    input wire logic [13:0] seg_len_i,
    input wire logic        ring_last_entry_i,
    input wire logic        group_addr_hit_i,
    input wire logic        unicast_addr_hit_i,
    input wire logic        bcast_addr_hit_i,
    input wire logic        crc_err_i,
    input wire logic        watchdog_err_i,
    input wire logic [1:0]  proto_class_i,
    input wire logic [2:0]  sums_i,
    input wire logic [15:0] tag_type_i,
    input wire logic [15:0] tag_control_bytes_i,
    input wire logic        wb_valid_o,
    input wire logic        wb_ready_i,
    input wire logic [31:0] wb_addr_o,
    input wire logic [31:0] wb_data_o
);
    logic [31:0] e1;
    logic [31:0] e2;
    wire         l  = seg_last_i;
    wire         rn = seg_len_i < 14'h0040;
    wire         tp = tag_type_i == 16'h8100;

    // expected words latched at take; held until the head beat is gone
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            e1 <= 32'h0;
            e2 <= 32'h0;
        end else if (seg_valid_i && seg_ready_o) begin
            e1 <= {1'b0, ring_last_entry_i, seg_first_i, l, group_addr_hit_i,
                   unicast_addr_hit_i, bcast_addr_hit_i, 2'h3, l & watchdog_err_i,
                   l & (crc_err_i | watchdog_err_i | rn), l & rn, l & crc_err_i,
                   proto_class_i, sums_i, l ? seg_len_i : 14'h0};
            e2 <= {15'h0, tp, tp ? tag_control_bytes_i : 16'h0};
        end
    end

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_head; wb_valid_o && wb_addr_o[3:0] == 4'h0; endsequence
    sequence s_tag; wb_valid_o && wb_addr_o[3:0] == 4'h4; endsequence

    property p_own; s_head |-> !wb_data_o[31]; endproperty
    property p_first; s_head |-> wb_data_o[29] == e1[29]; endproperty
    property p_last; s_head |-> wb_data_o[28] == e1[28]; endproperty
    property p_class; s_head |-> wb_data_o[27:25] == e1[27:25]; endproperty
    property p_err; s_head |-> wb_data_o[22:19] == e1[22:19]; endproperty
    property p_proto; s_head |-> wb_data_o[18:17] == e1[18:17]; endproperty
    property p_len; s_head |-> wb_data_o[13:0] == e1[13:0]; endproperty
    property p_sum; s_head |-> wb_data_o[16:14] == e1[16:14]; endproperty
    property p_tag; s_tag |-> wb_data_o == e2; endproperty
    // tag word first, ownership word straight after at the entry base
    property p_order;
        s_tag ##0 wb_ready_i |=> s_head ##0 wb_addr_o == $past(wb_addr_o) - 32'h4;
    endproperty
    a_own: assert property (p_own) else $error("own bit set");
    a_first: assert property (p_first) else $error("first flag");
    a_last: assert property (p_last) else $error("last flag");
    a_class: assert property (p_class) else $error("addr class");
    a_err: assert property (p_err) else $error("error bits");
    a_proto: assert property (p_proto) else $error("proto class");
    a_len: assert property (p_len) else $error("length");
    a_sum: assert property (p_sum) else $error("sum flags");
    a_tag: assert property (p_tag) else $error("tag word");
    a_order: assert property (p_order) else $error("beat order");
endmodule // rxs_wb_chk

bind rxs_writeback rxs_wb_chk u_chk (.clk_i, .arst_n_i, .seg_valid_i, .seg_ready_o,
    .seg_first_i, .seg_last_i, .seg_len_i, .ring_last_entry_i, .group_addr_hit_i,
    .unicast_addr_hit_i, .bcast_addr_hit_i, .crc_err_i, .watchdog_err_i, .proto_class_i,
    .sums_i({ip_sum_fail_i, udp_sum_fail_i, tcp_sum_fail_i}), .tag_type_i,
    .tag_control_bytes_i, .wb_valid_o, .wb_ready_i, .wb_addr_o, .wb_data_o);

// [bench/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic        seg_valid_i = 1'b0;
    logic        slow = 1'b0;
    logic [58:0] sf = 59'h0;
    logic [2:0]  ctl = 3'h0;
    logic [15:0] idx = 16'h0;
    logic        seg_first_i, seg_last_i, ring_last_entry_i, group_addr_hit_i;
    logic        unicast_addr_hit_i, bcast_addr_hit_i, crc_err_i, watchdog_err_i;
    logic        ip_sum_fail_i, udp_sum_fail_i, tcp_sum_fail_i, wb_ready_i, e;
    logic        pready_o, pslverr_o, seg_ready_o, wb_valid_o, frame_drop_o;
    logic [13:0] seg_len_i;
    logic [1:0]  proto_class_i;
    logic [15:0] tag_type_i, tag_control_bytes_i;
    logic [31:0] prdata_o, wb_addr_o, wb_data_o, head, tag, haddr, q;
    logic [7:0]  heads;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    // all segment fields move together, so one vector drives them
    assign {seg_first_i, seg_last_i, ring_last_entry_i, seg_len_i, group_addr_hit_i,
            unicast_addr_hit_i, bcast_addr_hit_i, crc_err_i, watchdog_err_i, proto_class_i,
            ip_sum_fail_i, udp_sum_fail_i, tcp_sum_fail_i, tag_type_i,
            tag_control_bytes_i} = sf;

    rxs_writeback uut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .seg_valid_i, .seg_ready_o, .seg_first_i, .seg_last_i,
        .seg_len_i, .ring_last_entry_i, .group_addr_hit_i, .unicast_addr_hit_i,
        .bcast_addr_hit_i, .crc_err_i, .watchdog_err_i, .proto_class_i, .ip_sum_fail_i,
        .udp_sum_fail_i, .tcp_sum_fail_i, .tag_type_i, .tag_control_bytes_i, .wb_valid_o,
        .wb_ready_i, .wb_addr_o, .wb_data_o, .frame_drop_o);
    rxs_host_mem host (.clk_i, .arst_n_i, .slow_i(slow), .wb_valid_i(wb_valid_o),
        .wb_addr_i(wb_addr_o), .wb_data_i(wb_data_o), .wb_ready_o(wb_ready_i),
        .head_o(head), .tag_o(tag), .addr_o(haddr), .heads_o(heads));

    initial forever #4 clk_i = ~clk_i;

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        samples_checked++;
        if (g !== w) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, w);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // m = {first, last, ring last, slow host}
    task automatic seg(input logic [3:0] m, input logic [13:0] n, input logic [2:0] c,
        input logic [1:0] er, input logic [4:0] ps, input logic [15:0] tt, input logic [15:0] tb);
        logic [31:0] x1;
        logic [7:0]  h0;
        logic        r;
        logic        d;
        logic        l;
        l = m[2];
        r = n < 14'h0040;
        d = m[3] && l && ((r && !ctl[1]) || (er[1] && !ctl[2]));
        x1 = {1'b0, m[1], m[3], l, c, 2'h3, l & er[0], l & (r || er != 2'h0), l & r,
              l & er[1], ps, l ? n : 14'h0};
        h0 = heads;
        @(posedge clk_i);
        slow <= m[0];
        sf <= {m[3], l, m[1], n, c, er, ps, tt, tb};
        seg_valid_i <= 1'b1;
        do @(posedge clk_i); while (seg_ready_o !== 1'b1);
        seg_valid_i <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, frame_drop_o}, {31'h0, d});
        if (!d) begin
            while (heads == h0) @(negedge clk_i);
            chk(head, x1);
            chk(tag, {15'h0, tt == 16'h8100, tt == 16'h8100 ? tb : 16'h0});
            chk(haddr, 32'h1000 + {idx, 4'h0});
            idx = m[1] ? 16'h0 : idx + 16'h1;
        end
    endtask

    // hang guard, well past the hundred or so cycles the tests need
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            test_done;
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({q[31:1], e}, 32'h1);
        apb(1'b1, 12'h004, 32'h0000_1008);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0000_1000);
        ctl = 3'h1;
        apb(1'b1, 12'h000, {29'h0, ctl});
        $display("test regs done");
        seg(4'hc, 14'h05ee, 3'h4, 2'h0, 5'h08, 16'h8100, 16'habcd);
        seg(4'h9, 14'h0100, 3'h2, 2'h3, 5'h07, 16'h0800, 16'h1234);
        seg(4'h7, 14'h003f, 3'h1, 2'h1, 5'h0c, 16'h8100, 16'h0fff);
        seg(4'hc, 14'h0040, 3'h2, 2'h2, 5'h00, 16'h0000, 16'h0000);
        seg(4'hc, 14'h003f, 3'h4, 2'h0, 5'h00, 16'h8100, 16'h5555);
        ctl = 3'h7;
        apb(1'b1, 12'h000, {29'h0, ctl});
        seg(4'hc, 14'h003f, 3'h1, 2'h2, 5'h08, 16'h8101, 16'h7777);
        seg(4'hd, 14'h3fff, 3'h7, 2'h0, 5'h1f, 16'h8100, 16'hffff);
        $display("test frames done");
        apb(1'b0, 12'h008, 32'h0);
        chk(q, {16'h0, idx});
        apb(1'b0, 12'h00c, 32'h0);
        chk(q, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 32'h5);
        $display("test counts done");
        test_done;
    end
endmodule // tb_top

// [hdl/rxs_pkg.sv]
package rxs_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_RING_BASE = 12'h004;
    localparam logic [11:0] OFS_STATUS    = 12'h008;
    localparam logic [11:0] OFS_DROP_CNT  = 12'h00c;
    localparam logic [11:0] OFS_FRAME_CNT = 12'h010;

    // control register fields and reset values
    localparam int unsigned CTRL_W              = 3;
    localparam int unsigned CTRL_ENABLE_BIT     = 0;
    localparam int unsigned CTRL_ACC_SHORT_BIT  = 1;
    localparam int unsigned CTRL_ACC_BADFCS_BIT = 2;
    localparam logic [2:0]  CTRL_RST            = 3'h0;
    localparam logic [31:0] RING_BASE_RST       = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST           = 32'h0000_0000;

    // status register fields
    localparam int unsigned STAT_IDX_W    = 16;
    localparam int unsigned STAT_BUSY_BIT = 16;

    // status descriptor, first word
    localparam int unsigned W0_OWN       = 31;
    localparam int unsigned W0_RING_LAST = 30;
    localparam int unsigned W0_FIRST     = 29;
    localparam int unsigned W0_LAST      = 28;
    localparam int unsigned W0_GROUP     = 27;
    localparam int unsigned W0_UNICAST   = 26;
    localparam int unsigned W0_BCAST     = 25;
    localparam int unsigned W0_RSVD_HI   = 24;
    localparam int unsigned W0_RSVD_LO   = 23;
    localparam int unsigned W0_WDOG      = 22;
    localparam int unsigned W0_ERR_SUM   = 21;
    localparam int unsigned W0_RUNT      = 20;
    localparam int unsigned W0_FCS       = 19;
    localparam int unsigned W0_PROTO_HI  = 18;
    localparam int unsigned W0_PROTO_LO  = 17;
    localparam int unsigned W0_IP_FAIL   = 16;
    localparam int unsigned W0_UDP_FAIL  = 15;
    localparam int unsigned W0_TCP_FAIL  = 14;
    localparam int unsigned LEN_W        = 14;

    // status descriptor, second word
    localparam int unsigned W1_TAG_PRESENT = 16;
    localparam int unsigned TAG_W          = 16;

    // descriptor geometry: 16 bytes per entry, second word at +4
    localparam int unsigned DESC_SHIFT   = 4;
    localparam logic [31:0] DESC_W1_OFS  = 32'h0000_0004;

    // frame classification constants
    localparam logic [13:0] MIN_FRAME_LEN = 14'h0040;
    localparam logic [15:0] TAG_TPID      = 16'h8100;
    localparam logic [1:0]  PROTO_NON_IP  = 2'h0;
    localparam logic [1:0]  PROTO_TCP_IP  = 2'h1;

    // write-back sequencer states
    typedef enum logic [2:0] {
        RXS_IDLE    = 3'h1,
        RXS_WR_TAG  = 3'h2,
        RXS_WR_HEAD = 3'h4
    } rxs_state_e;

endpackage

// [hdl/rxs_ring_ptr.sv]
`timescale 1ns/10ps

module rxs_ring_ptr #(
    parameter int unsigned IDX_W = 10
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             clear_i,
    input  wire logic             advance_i,
    input  wire logic             wrap_i,
    output logic      [IDX_W-1:0] idx_o
);

    typedef struct packed {
        logic [IDX_W-1:0] idx;
    } rxs_ptr_state_s;

    rxs_ptr_state_s cur;
    rxs_ptr_state_s next_cur;

    // pointer steps only when a descriptor was handed back, and returns to zero on clear_i
    always_comb begin
        next_cur = cur;
        if (clear_i) begin
            next_cur.idx = '0;
        end else if (advance_i) begin
            if (wrap_i) begin
                next_cur.idx = '0;
            end else begin
                next_cur.idx = cur.idx + IDX_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign idx_o = cur.idx;

endmodule // rxs_ring_ptr

// [hdl/rxs_writeback.sv]
`timescale 1ns/10ps


module rxs_writeback #(
    parameter int unsigned IDX_W = 10
) (
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    // apb slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // finished segment from the receive engine
    input  wire logic                 seg_valid_i,
    output logic                      seg_ready_o,
    input  wire logic                 seg_first_i,
    input  wire logic                 seg_last_i,
    input  wire logic [13:0]          seg_len_i,
    input  wire logic                 ring_last_entry_i,
    input  wire logic                 group_addr_hit_i,
    input  wire logic                 unicast_addr_hit_i,
    input  wire logic                 bcast_addr_hit_i,
    input  wire logic                 crc_err_i,
    input  wire logic                 watchdog_err_i,
    input  wire logic [1:0]           proto_class_i,
    input  wire logic                 ip_sum_fail_i,
    input  wire logic                 udp_sum_fail_i,
    input  wire logic                 tcp_sum_fail_i,
    input  wire logic [15:0]          tag_type_i,
    input  wire logic [15:0]          tag_control_bytes_i,
    // descriptor write port toward system memory
    output logic                      wb_valid_o,
    input  wire logic                 wb_ready_i,
    output logic      [31:0]          wb_addr_o,
    output logic      [31:0]          wb_data_o,
    output logic                      frame_drop_o
);

    // block state other than the ring pointer in one packed word; next_cur is the copy the
    // combinational half fills and the flop bank below registers
    // read data and the bus error flag live here too, so prdata comes straight
    // from a flop and pslverr from a flop gated by psel and penable
    typedef struct packed {
        rxs_pkg::rxs_state_e st;
        logic [2:0]          ctrl;
        logic [31:0]         ring_base;
        logic [31:0]         drop_cnt;
        logic [31:0]         frame_cnt;
        logic [31:0]         prdata;
        logic                pslverr;
        logic [31:0]         word0;
        logic                ring_last;
        logic [31:0]         wb_addr;
        logic [31:0]         wb_data;
        logic                drop;
    } rxs_wb_state_s;

    // state copies, pointer strobes and decoded bus phases
    rxs_wb_state_s    cur;
    rxs_wb_state_s    next_cur;
    logic [IDX_W-1:0] ring_idx;
    logic             ptr_clear;
    logic             ptr_advance;
    logic             ptr_wrap;
    logic [31:0]      desc_addr;
    logic             apb_setup;
    logic             apb_write;
    logic             seg_take;

    // descriptor base of the entry in use
    // entries are 16 bytes apart, so the index sits above four zero bits
    assign desc_addr = cur.ring_base +
                       {{(32 - IDX_W - rxs_pkg::DESC_SHIFT){1'b0}}, ring_idx, 4'h0};

    // bus phase decode
    // pready is tied high, so the access phase always ends in one cycle
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pwrite_i;
    assign seg_take  = seg_valid_i & seg_ready_o;

    // next-state logic: register file, status build, write sequencer
    always_comb begin
        logic        runt;
        logic        fcs_bad;
        logic        wdog;
        logic        keep_short;
        logic        keep_bad;
        logic [31:0] w0;
        logic [31:0] w1;
        // defaults first: the drop pulse clears, nothing else moves unless a branch below asks for it
        runt        = 1'b0;
        fcs_bad     = 1'b0;
        wdog        = 1'b0;
        keep_short  = cur.ctrl[rxs_pkg::CTRL_ACC_SHORT_BIT];
        keep_bad    = cur.ctrl[rxs_pkg::CTRL_ACC_BADFCS_BIT];
        w0          = '0;
        w1          = '0;
        next_cur    = cur;
        next_cur.drop = 1'b0;
        ptr_clear   = 1'b0;
        ptr_advance = 1'b0;
        ptr_wrap    = 1'b0;

        // read data captured in the setup phase so prdata comes from a flop
        if (apb_setup) begin
            next_cur.pslverr = 1'b0;
            case (paddr_i)
                rxs_pkg::OFS_CTRL: begin
                    next_cur.prdata = {29'h0, cur.ctrl};
                end
                rxs_pkg::OFS_RING_BASE: begin
                    next_cur.prdata = cur.ring_base;
                end
                rxs_pkg::OFS_STATUS: begin
                    next_cur.prdata = {15'h0, (cur.st != rxs_pkg::RXS_IDLE),
                                       {(rxs_pkg::STAT_IDX_W - IDX_W){1'b0}}, ring_idx};
                end
                rxs_pkg::OFS_DROP_CNT: begin
                    next_cur.prdata = cur.drop_cnt;
                end
                rxs_pkg::OFS_FRAME_CNT: begin
                    next_cur.prdata = cur.frame_cnt;
                end
                default: begin
                    next_cur.prdata  = 32'h0000_0000;
                    next_cur.pslverr = 1'b1;
                end
            endcase
        end

        // writes take effect at the access edge; counters written clear
        if (apb_write) begin
            case (paddr_i)
                rxs_pkg::OFS_CTRL: begin
                    next_cur.ctrl = pwdata_i[rxs_pkg::CTRL_W-1:0];
                end
                rxs_pkg::OFS_RING_BASE: begin
                    // a new ring restarts at entry zero; do not move it mid write-back
                    next_cur.ring_base = {pwdata_i[31:rxs_pkg::DESC_SHIFT], 4'h0};
                    ptr_clear          = 1'b1;
                end
                rxs_pkg::OFS_DROP_CNT: begin
                    next_cur.drop_cnt = rxs_pkg::COUNT_RST;
                end
                rxs_pkg::OFS_FRAME_CNT: begin
                    next_cur.frame_cnt = rxs_pkg::COUNT_RST;
                end
                default: begin
                    // status and unmapped offsets ignore writes; an unmapped
                    // one already raised the error flag in the setup phase
                    next_cur.ctrl = next_cur.ctrl;
                end
            endcase
        end

        // error flags only mean something once the whole frame is in
        // a frame cut into segments reports its errors in the closing one
        runt    = seg_last_i & (seg_len_i < rxs_pkg::MIN_FRAME_LEN);
        fcs_bad = seg_last_i & crc_err_i;
        wdog    = seg_last_i & watchdog_err_i;

        // first status word; ownership stays zero
        w0[rxs_pkg::W0_OWN]       = 1'b0;
        w0[rxs_pkg::W0_RING_LAST] = ring_last_entry_i;
        w0[rxs_pkg::W0_FIRST]     = seg_first_i;
        w0[rxs_pkg::W0_LAST]      = seg_last_i;
        w0[rxs_pkg::W0_GROUP]     = group_addr_hit_i;
        w0[rxs_pkg::W0_UNICAST]   = unicast_addr_hit_i;
        w0[rxs_pkg::W0_BCAST]     = bcast_addr_hit_i;
        w0[rxs_pkg::W0_RSVD_HI]   = 1'b1;
        w0[rxs_pkg::W0_RSVD_LO]   = 1'b1;
        w0[rxs_pkg::W0_WDOG]      = wdog;
        w0[rxs_pkg::W0_ERR_SUM]   = fcs_bad | runt | wdog;
        w0[rxs_pkg::W0_RUNT]      = runt;
        w0[rxs_pkg::W0_FCS]       = fcs_bad;
        w0[rxs_pkg::W0_PROTO_HI]  = proto_class_i[1];
        w0[rxs_pkg::W0_PROTO_LO]  = proto_class_i[0];
        w0[rxs_pkg::W0_IP_FAIL]   = ip_sum_fail_i;
        w0[rxs_pkg::W0_UDP_FAIL]  = udp_sum_fail_i;
        w0[rxs_pkg::W0_TCP_FAIL]  = tcp_sum_fail_i;
        // earlier segments leave the length field at zero; the host must
        // only trust it once the closing segment arrives
        if (seg_last_i) begin
            w0[rxs_pkg::LEN_W-1:0] = seg_len_i;
        end

        // second status word carries the tag only when the tpid matched
        if (tag_type_i == rxs_pkg::TAG_TPID) begin
            w1[rxs_pkg::W1_TAG_PRESENT]    = 1'b1;
            w1[rxs_pkg::TAG_W-1:0]         = tag_control_bytes_i;
        end

        // sequencer: tag word first, ownership word last so the host never
        // sees a released descriptor with stale status
        // the cost is one extra cycle per descriptor against one wide beat
        case (cur.st)
            rxs_pkg::RXS_IDLE: begin
                if (seg_take) begin
                    // only a one-buffer frame can still be discarded; earlier
                    // segments of a longer frame already belong to the host
                    if (seg_first_i & seg_last_i &
                        ((runt & ~keep_short) | (fcs_bad & ~keep_bad))) begin
                        // no write-back and no pointer move: the buffer stays ours
                        next_cur.drop     = 1'b1;
                        next_cur.drop_cnt = next_cur.drop_cnt + 32'h0000_0001;
                    end else begin
                        next_cur.word0     = w0;
                        next_cur.ring_last = ring_last_entry_i;
                        next_cur.wb_addr   = desc_addr + rxs_pkg::DESC_W1_OFS;
                        next_cur.wb_data   = w1;
                        next_cur.st        = rxs_pkg::RXS_WR_TAG;
                    end
                end
            end
            rxs_pkg::RXS_WR_TAG: begin
                // word0 was frozen at the take, so inputs moving on after the
                // handshake cannot leak into the status the host will read
                if (wb_ready_i) begin
                    next_cur.wb_addr = desc_addr;
                    next_cur.wb_data = cur.word0;
                    next_cur.st      = rxs_pkg::RXS_WR_HEAD;
                end
            end
            rxs_pkg::RXS_WR_HEAD: begin
                // pointer and frame count move only once the host owns the entry;
                // a stalled memory simply holds this beat up
                if (wb_ready_i) begin
                    ptr_advance        = 1'b1;
                    ptr_wrap           = cur.ring_last;
                    next_cur.frame_cnt = next_cur.frame_cnt + 32'h0000_0001;
                    next_cur.st        = rxs_pkg::RXS_IDLE;
                end
            end
            default: begin
                // an illegal code drops a half-done write-back rather than hang
                next_cur.st = rxs_pkg::RXS_IDLE;
            end
        endcase
    end

    // single state register
    // reset loads constants only; the pointer resets in its own module
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur.st        <= rxs_pkg::RXS_IDLE;
            cur.ctrl      <= rxs_pkg::CTRL_RST;
            cur.ring_base <= rxs_pkg::RING_BASE_RST;
            cur.drop_cnt  <= rxs_pkg::COUNT_RST;
            cur.frame_cnt <= rxs_pkg::COUNT_RST;
            cur.prdata    <= 32'h0000_0000;
            cur.pslverr   <= 1'b0;
            cur.word0     <= 32'h0000_0000;
            cur.ring_last <= 1'b0;
            cur.wb_addr   <= 32'h0000_0000;
            cur.wb_data   <= 32'h0000_0000;
            cur.drop      <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // receive ring pointer
    // kept apart so that wrap, clear and step sit in one small register
    rxs_ring_ptr #(
        .IDX_W (IDX_W)
    ) u_ring_ptr (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (ptr_clear),
        .advance_i (ptr_advance),
        .wrap_i    (ptr_wrap),
        .idx_o     (ring_idx)
    );

    // outputs; zero-wait slave, error only shown in the access phase
    // seg_ready falls while busy, so at most one descriptor is in flight
    assign prdata_o     = cur.prdata;
    assign pready_o     = 1'b1;
    assign pslverr_o    = cur.pslverr & psel_i & penable_i;
    assign seg_ready_o  = (cur.st == rxs_pkg::RXS_IDLE) & cur.ctrl[rxs_pkg::CTRL_ENABLE_BIT];
    assign wb_valid_o   = (cur.st != rxs_pkg::RXS_IDLE);
    assign wb_addr_o    = cur.wb_addr;
    assign wb_data_o    = cur.wb_data;
    assign frame_drop_o = cur.drop;

endmodule // rxs_writeback
